// ---- shared/rld_params.svh ----
// Register offsets, field positions, reset values and size codes of the run-length decoder.
// Included by the package and by both ends; holds definitions only.
`ifndef RLD_PARAMS_SVH
`define RLD_PARAMS_SVH

// Decoder settings, reached through the link's configuration port
`define RLD_OFF_CTRL 8'h00
`define RLD_OFF_CSIZE 8'h04
`define RLD_OFF_DIM 8'h08
`define RLD_OFF_START 8'h0C
`define RLD_OFF_END 8'h10
`define RLD_OFF_ICFG 8'h14
`define RLD_OFF_THR 8'h18
// Controller's own registers on APB
`define RLD_OFF_DMA_CTRL 8'h20
`define RLD_OFF_STAT 8'h24
`define RLD_OFF_XFER 8'h28

// Field positions
`define RLD_CTRL_DISABLE 0
`define RLD_CMD_RUN 7
`define RLD_DMA_IN_EN 0
`define RLD_DMA_OUT_EN 1

// Reset values
`define RLD_DISABLE_RST 1'b1
`define RLD_IN_THR_RST 8'h08
`define RLD_OUT_THR_RST 8'h03
`define RLD_COORD_RST 16'h0001

// Access size codes
`define RLD_SZ_8 2'h0
`define RLD_SZ_16 2'h1
`define RLD_SZ_32 2'h2

`endif

// ---- shared/rld_pkg.sv ----
// Types shared by both ends of the run-length decoder link.
// Assumes rld_params.svh on the include path.
`include "rld_params.svh"

package rld_pkg;

	typedef enum logic [2:0] {
		RLD_ST_IDLE = 3'h0,
		RLD_ST_CMD = 3'h1,
		RLD_ST_PIX = 3'h2,
		RLD_ST_EMIT = 3'h3,
		RLD_ST_DONE = 3'h4
	} rld_state_e;

	// Bytes moved by one access of the given size code
	function automatic logic [2:0] rld_size_bytes(input logic [1:0] sz);
		logic [2:0] nb;
		nb = 3'h4;
		if (sz == `RLD_SZ_8) nb = 3'h1;
		else if (sz == `RLD_SZ_16) nb = 3'h2;
		return nb;
	endfunction : rld_size_bytes

endpackage : rld_pkg

// ---- shared/rld_if.sv ----
// Link between the decoder and the DMA controller that feeds and drains it.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps

interface rld_if;
	logic cfg_wr;
	logic [7:0] cfg_addr;
	logic [31:0] cfg_wdata;
	logic in_wr;
	logic [1:0] in_size;
	logic [31:0] in_wdata;
	logic out_rd;
	logic [1:0] out_size;
	logic [31:0] out_rdata;
	logic in_req;
	logic out_req;
	logic [15:0] in_level;
	logic [15:0] out_level;
	logic busy;
	logic done;

	modport dec (
		input cfg_wr, cfg_addr, cfg_wdata, in_wr, in_size, in_wdata, out_rd, out_size,
		output out_rdata, in_req, out_req, in_level, out_level, busy, done
	);

	modport dma (
		output cfg_wr, cfg_addr, cfg_wdata, in_wr, in_size, in_wdata, out_rd, out_size,
		input out_rdata, in_req, out_req, in_level, out_level, busy, done
	);
endinterface : rld_if

// ---- hw/rld_decoder.sv ----
// Run-length decoder: byte-wide input and output FIFOs, frame parser, crop window.
// Assumes a DMA end on the same clock that honours the FIFO requests.
// How it works
// - Each frame opens with an 8-bit command
// - Command bit 7 set means run
// - Pixel count is low seven bits plus one
// - Run: one pixel, repeated count times
// - Literal: count pixels passed unchanged
// - Symbols of 8, 16, 24, 32 bits
// - Raster order, runs wrap across rows
// - Input request while enabled and level below threshold
// - Output request while level above threshold
// - Feeder bursts fit input free space
// - Drainer bursts never exceed output level
// - FIFO ports take 8/16/32-bit accesses
// - Program while disabled; enabling starts decoding
// - Holds total compressed input size
// - Holds width, height; tracks pixel coordinates
// - Only pixels inside crop rectangle leave
// - Crop start and end points inclusive
// - Symbol size from pixel-format field
// - Non-image data: width=count, height 1
// - Long data split into independent packets
`timescale 1ns/1ps
`include "rld_params.svh"

module rld_decoder
	import rld_pkg::*;
#(
	parameter int IN_DEPTH = 32,
	parameter int OUT_DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	rld_if.dec bus
);

	localparam int IAW = $clog2(IN_DEPTH);
	localparam int OAW = $clog2(OUT_DEPTH);

	typedef struct packed {
		logic module_disable;
		logic [31:0] comp_size;
		logic [15:0] img_w;
		logic [15:0] img_h;
		logic [15:0] sx;
		logic [15:0] sy;
		logic [15:0] ex;
		logic [15:0] ey;
		logic [1:0] fmt;
		logic [7:0] in_thr;
		logic [7:0] out_thr;
		logic [IN_DEPTH-1:0][7:0] imem;
		logic [IAW:0] iwp;
		logic [IAW:0] irp;
		logic [OUT_DEPTH-1:0][7:0] omem;
		logic [OAW:0] owp;
		logic [OAW:0] orp;
		rld_state_e st;
		logic run;
		logic [6:0] cnt;
		logic [1:0] bidx;
		logic [31:0] pix;
		logic [31:0] consumed;
		logic [15:0] x;
		logic [15:0] y;
		logic done;
	} rld_dec_s;

	rld_dec_s r_reg;
	rld_dec_s r_next;
	logic [IAW:0] ilvl;
	logic [OAW:0] olvl;
	logic [OAW:0] ofree;
	logic [2:0] pbytes;
	logic [2:0] in_nb;
	logic [2:0] out_nb;
	logic [7:0] ibyte;
	logic in_crop;
	logic last_pix;
	logic [31:0] rdata;

	always_comb begin
		r_next = r_reg;
		ilvl = r_reg.iwp - r_reg.irp;
		olvl = r_reg.owp - r_reg.orp;
		ofree = (OAW+1)'(OUT_DEPTH) - olvl;
		pbytes = {1'b0, r_reg.fmt} + 3'h1;
		in_nb = rld_size_bytes(bus.in_size);
		out_nb = rld_size_bytes(bus.out_size);
		ibyte = r_reg.imem[r_reg.irp[IAW-1:0]];
		in_crop = (r_reg.x >= r_reg.sx) && (r_reg.x <= r_reg.ex) &&
			(r_reg.y >= r_reg.sy) && (r_reg.y <= r_reg.ey);
		last_pix = (r_reg.bidx == pbytes[1:0] - 2'h1);

		// Read data, low lanes first
		rdata = 32'h0;
		for (int i = 0; i < 4; i++) begin
			if (3'(i) < out_nb) begin
				rdata[8*i +: 8] = r_reg.omem[r_reg.orp[OAW-1:0] + OAW'(i)];
			end
		end

		// Settings: control always, the rest only while disabled
		if (bus.cfg_wr) begin
			if (bus.cfg_addr == `RLD_OFF_CTRL) begin
				r_next.module_disable = bus.cfg_wdata[`RLD_CTRL_DISABLE];
			end else if (r_reg.module_disable) begin
				case (bus.cfg_addr)
					`RLD_OFF_CSIZE: r_next.comp_size = bus.cfg_wdata;
					`RLD_OFF_DIM: begin
						r_next.img_w = bus.cfg_wdata[15:0];
						r_next.img_h = bus.cfg_wdata[31:16];
					end
					`RLD_OFF_START: begin
						r_next.sx = bus.cfg_wdata[15:0];
						r_next.sy = bus.cfg_wdata[31:16];
					end
					`RLD_OFF_END: begin
						r_next.ex = bus.cfg_wdata[15:0];
						r_next.ey = bus.cfg_wdata[31:16];
					end
					`RLD_OFF_ICFG: r_next.fmt = bus.cfg_wdata[1:0];
					`RLD_OFF_THR: begin
						r_next.in_thr = bus.cfg_wdata[7:0];
						r_next.out_thr = bus.cfg_wdata[15:8];
					end
					default: ;
				endcase
			end
		end

		// Input FIFO push; a write that does not fit is dropped
		if (bus.in_wr && (int'(ilvl) + int'(in_nb) <= IN_DEPTH)) begin
			for (int i = 0; i < 4; i++) begin
				if (3'(i) < in_nb) begin
					r_next.imem[r_reg.iwp[IAW-1:0] + IAW'(i)] = bus.in_wdata[8*i +: 8];
				end
			end
			r_next.iwp = r_reg.iwp + (IAW+1)'(in_nb);
		end

		// Output FIFO pop; a read past the level leaves the read pointer where it is
		if (bus.out_rd && (int'(olvl) >= int'(out_nb))) begin
			r_next.orp = r_reg.orp + (OAW+1)'(out_nb);
		end

		// Frame parser
		if (r_reg.module_disable) begin
			r_next.st = RLD_ST_IDLE;
		end else begin
			unique case (r_reg.st)
				RLD_ST_IDLE: begin
					r_next.consumed = 32'h0;
					r_next.x = `RLD_COORD_RST;
					r_next.y = `RLD_COORD_RST;
					r_next.done = 1'b0;
					r_next.st = RLD_ST_CMD;
				end
				RLD_ST_CMD: begin
					if (r_reg.consumed >= r_reg.comp_size) begin
						r_next.st = RLD_ST_DONE;
					end else if (ilvl != '0) begin
						r_next.irp = r_reg.irp + (IAW+1)'(1);
						r_next.consumed = r_reg.consumed + 32'h1;
						r_next.run = ibyte[`RLD_CMD_RUN];
						r_next.cnt = ibyte[6:0];
						r_next.bidx = 2'h0;
						r_next.st = RLD_ST_PIX;
					end
				end
				RLD_ST_PIX: begin
					if (ilvl != '0) begin
						r_next.irp = r_reg.irp + (IAW+1)'(1);
						r_next.consumed = r_reg.consumed + 32'h1;
						if (r_reg.bidx == 2'h0) begin
							r_next.pix = {24'h0, ibyte};
						end else begin
							r_next.pix[8*r_reg.bidx +: 8] = ibyte;
						end
						if (last_pix) begin
							r_next.st = RLD_ST_EMIT;
						end else begin
							r_next.bidx = r_reg.bidx + 2'h1;
						end
					end
				end
				RLD_ST_EMIT: begin
					if (!in_crop || (ofree >= (OAW+1)'(pbytes))) begin
						if (in_crop) begin
							for (int i = 0; i < 4; i++) begin
								if (3'(i) < pbytes) begin
									r_next.omem[r_reg.owp[OAW-1:0] + OAW'(i)] = r_reg.pix[8*i +: 8];
								end
							end
							r_next.owp = r_reg.owp + (OAW+1)'(pbytes);
						end
						if (r_reg.x >= r_reg.img_w) begin
							r_next.x = `RLD_COORD_RST;
							r_next.y = r_reg.y + 16'h1;
						end else begin
							r_next.x = r_reg.x + 16'h1;
						end
						if (r_reg.cnt == 7'h0) begin
							r_next.st = RLD_ST_CMD;
						end else begin
							r_next.cnt = r_reg.cnt - 7'h1;
							if (!r_reg.run) begin
								r_next.bidx = 2'h0;
								r_next.st = RLD_ST_PIX;
							end
						end
					end
				end
				RLD_ST_DONE: begin
					r_next.done = 1'b1;
				end
				default: r_next.st = RLD_ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
			r_reg.module_disable <= `RLD_DISABLE_RST;
			r_reg.in_thr <= `RLD_IN_THR_RST;
			r_reg.out_thr <= `RLD_OUT_THR_RST;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign bus.out_rdata = rdata;
	assign bus.in_req = !r_reg.module_disable && (int'(ilvl) < int'(r_reg.in_thr));
	assign bus.out_req = int'(olvl) > int'(r_reg.out_thr);
	assign bus.in_level = 16'(ilvl);
	assign bus.out_level = 16'(olvl);
	assign bus.busy = (r_reg.st != RLD_ST_IDLE) && (r_reg.st != RLD_ST_DONE);
	assign bus.done = r_reg.done && (olvl == '0);

endmodule : rld_decoder

// ---- hw/rld_dma_ctrl.sv ----
// DMA controller end: APB registers, feeding and draining channels for the decoder.
// Assumes a word source and sink on the same pclk with valid/ready handshakes.
`timescale 1ns/1ps
`include "rld_params.svh"

module rld_dma_ctrl
	import rld_pkg::*;
#(
	parameter int IN_DEPTH = 32,
	parameter int OUT_DEPTH = 32,
	parameter int IN_BURST = 4,
	parameter int OUT_BURST = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic src_valid,
	input wire logic [31:0] src_data,
	output logic src_ready,
	output logic dst_valid,
	output logic [31:0] dst_data,
	input wire logic dst_ready,
	rld_if.dma bus
);

	typedef struct packed {
		logic [5:0] dma_ctrl;
		logic [7:0] in_left;
		logic [7:0] out_left;
		logic dst_valid;
		logic [31:0] dst_data;
		logic [31:0] xfer_cnt;
		logic [31:0] prdata;
	} rld_dma_s;

	rld_dma_s r_reg;
	rld_dma_s r_next;
	logic pass_hit;
	logic own_hit;
	logic in_go;
	logic out_go;
	logic [2:0] in_bytes;
	logic [2:0] out_bytes;

	always_comb begin
		r_next = r_reg;
		pass_hit = (paddr <= `RLD_OFF_THR) && (paddr[1:0] == 2'h0);
		own_hit = (paddr == `RLD_OFF_DMA_CTRL) || (paddr == `RLD_OFF_STAT) || (paddr == `RLD_OFF_XFER);
		in_bytes = rld_size_bytes(r_reg.dma_ctrl[3:2]);
		out_bytes = rld_size_bytes(r_reg.dma_ctrl[5:4]);

		// Read data captured in the setup cycle
		if (psel && !penable) begin
			case (paddr)
				`RLD_OFF_DMA_CTRL: r_next.prdata = {26'h0, r_reg.dma_ctrl};
				`RLD_OFF_STAT: r_next.prdata = {bus.out_level[7:0], bus.in_level[7:0], 14'h0, bus.busy, bus.done};
				`RLD_OFF_XFER: r_next.prdata = r_reg.xfer_cnt;
				default: r_next.prdata = 32'h0;
			endcase
		end
		if (psel && penable && pwrite && (paddr == `RLD_OFF_DMA_CTRL)) begin
			r_next.dma_ctrl = pwdata[5:0];
		end

		// Feeding channel: a burst starts only if it fits the free space
		in_go = (r_reg.in_left != 8'h0) && src_valid;
		if (in_go) begin
			r_next.in_left = r_reg.in_left - 8'h1;
		end else if ((r_reg.in_left == 8'h0) && r_reg.dma_ctrl[`RLD_DMA_IN_EN] && bus.in_req &&
			(int'(bus.in_level) + IN_BURST * int'(in_bytes) <= IN_DEPTH)) begin
			r_next.in_left = 8'(IN_BURST);
		end

		// Draining channel: a burst starts only if the level covers it
		out_go = (r_reg.out_left != 8'h0) && (!r_reg.dst_valid || dst_ready);
		if (out_go) begin
			r_next.out_left = r_reg.out_left - 8'h1;
			r_next.dst_data = bus.out_rdata;
			r_next.dst_valid = 1'b1;
			r_next.xfer_cnt = r_reg.xfer_cnt + 32'h1;
		end else begin
			if (dst_ready) begin
				r_next.dst_valid = 1'b0;
			end
			if ((r_reg.out_left == 8'h0) && r_reg.dma_ctrl[`RLD_DMA_OUT_EN] && bus.out_req &&
				(int'(bus.out_level) >= OUT_BURST * int'(out_bytes)) &&
				(OUT_BURST * int'(out_bytes) <= OUT_DEPTH)) begin
				r_next.out_left = 8'(OUT_BURST);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_reg <= '0;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	assign prdata = r_reg.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !pass_hit && !own_hit;
	assign src_ready = in_go;
	assign dst_valid = r_reg.dst_valid;
	assign dst_data = r_reg.dst_data;
	assign bus.cfg_wr = ce && psel && penable && pwrite && pass_hit;
	assign bus.cfg_addr = paddr;
	assign bus.cfg_wdata = pwdata;
	assign bus.in_wr = ce && in_go;
	assign bus.in_size = r_reg.dma_ctrl[3:2];
	assign bus.in_wdata = src_data;
	assign bus.out_rd = ce && out_go;
	assign bus.out_size = r_reg.dma_ctrl[5:4];

endmodule : rld_dma_ctrl

// ---- bench/rld_link_sva.sv ----
// Checker for the decoder link: FIFO requests, levels, enable and completion.
// Assumes it watches the signals of one rld_if on pclk, instantiated beside it.
`timescale 1ns/1ps
`include "rld_params.svh"

module rld_link_sva #(
	parameter int IN_DEPTH = 32,
	parameter int OUT_DEPTH = 32
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic in_wr,
	input wire logic [1:0] in_size,
	input wire logic out_rd,
	input wire logic [1:0] out_size,
	input wire logic in_req,
	input wire logic out_req,
	input wire logic [15:0] in_level,
	input wire logic [15:0] out_level,
	input wire logic busy,
	input wire logic done
);
	logic dis_reg;
	logic [7:0] thr_in_reg;
	logic [7:0] thr_out_reg;

	function automatic logic [15:0] nb(input logic [1:0] s);
		return (s == `RLD_SZ_8) ? 16'h0001 : (s == `RLD_SZ_16) ? 16'h0002 : 16'h0004;
	endfunction : nb

	// Tracks disable and thresholds as written over the link
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dis_reg <= `RLD_DISABLE_RST;
			thr_in_reg <= `RLD_IN_THR_RST;
			thr_out_reg <= `RLD_OUT_THR_RST;
		end else if (cfg_wr && cfg_addr == `RLD_OFF_CTRL) begin
			dis_reg <= cfg_wdata[`RLD_CTRL_DISABLE];
		end else if (cfg_wr && cfg_addr == `RLD_OFF_THR && dis_reg) begin
			thr_in_reg <= cfg_wdata[7:0];
			thr_out_reg <= cfg_wdata[15:8];
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_in_req_low; in_req |-> !dis_reg && in_level < 16'(thr_in_reg); endproperty
	a_in_req_low: assert property (p_in_req_low) else $error("in_req without room");
	property p_in_req_set; !dis_reg && in_level < 16'(thr_in_reg) |-> ##[0:1] in_req; endproperty
	a_in_req_set: assert property (p_in_req_set) else $error("in_req missing");
	property p_out_req_high; out_req |-> out_level > 16'(thr_out_reg); endproperty
	a_out_req_high: assert property (p_out_req_high) else $error("out_req without data");
	property p_out_req_set; out_level > 16'(thr_out_reg) |-> ##[0:1] out_req; endproperty
	a_out_req_set: assert property (p_out_req_set) else $error("out_req missing");
	property p_in_room; in_wr |-> in_level + nb(in_size) <= 16'(IN_DEPTH); endproperty
	a_in_room: assert property (p_in_room) else $error("input push overflows");
	property p_out_avail; out_rd |-> out_level >= nb(out_size); endproperty
	a_out_avail: assert property (p_out_avail) else $error("output pop underruns");
	property p_push_size; in_wr |=> in_level == $past(in_level) + nb($past(in_size))
		|| in_level + 16'h0001 == $past(in_level) + nb($past(in_size)); endproperty
	a_push_size: assert property (p_push_size) else $error("push size not applied");
	property p_dis_idle; dis_reg && $past(dis_reg) |-> !busy; endproperty
	a_dis_idle: assert property (p_dis_idle) else $error("busy while disabled");
	property p_start; $fell(dis_reg) |-> ##[1:3] busy; endproperty
	a_start: assert property (p_start) else $error("no start after enable");
	property p_done_empty; done |-> out_level == 16'h0000 && !busy; endproperty
	a_done_empty: assert property (p_done_empty) else $error("done with output pending");
endmodule : rld_link_sva

// ---- bench/run_length_stream_decoder_tb.sv ----
// Testbench: decoder and DMA end joined by rld_if, driven over APB and the word streams.
// Assumes the shared include path and the rld_link_sva checker.
`timescale 1ns/1ps
`include "rld_params.svh"

module run_length_stream_decoder_tb import rld_pkg::*;;
	typedef logic [7:0] rld_bq_t [$];
	logic pclk = 1'b0;
	logic presetn;
	logic ce;
	logic [7:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic src_valid = 1'b0;
	logic [31:0] src_data = 32'h0;
	logic src_ready;
	logic dst_valid;
	logic [31:0] dst_data;
	logic dst_ready = 1'b0;
	logic [1:0] stall_cnt = 2'h0;
	logic [1:0] dsz = 2'h2;
	logic [31:0] rd_data;
	logic rd_err;
	int n_mismatch;
	int n_checks;
	int n_words;
	logic [31:0] src_q [$];
	rld_bq_t exp_q;
	rld_bq_t got_q;

	rld_if bus_if ();
	rld_decoder i_rld_decoder (.pclk(pclk), .presetn(presetn), .ce(ce), .bus(bus_if.dec));
	rld_dma_ctrl i_rld_dma_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
		.dst_valid(dst_valid), .dst_data(dst_data), .dst_ready(dst_ready), .bus(bus_if.dma));
	rld_link_sva #(.IN_DEPTH(32), .OUT_DEPTH(32)) i_rld_link_sva (.pclk(pclk), .presetn(presetn),
		.cfg_wr(bus_if.cfg_wr), .cfg_addr(bus_if.cfg_addr), .cfg_wdata(bus_if.cfg_wdata),
		.in_wr(bus_if.in_wr), .in_size(bus_if.in_size), .out_rd(bus_if.out_rd),
		.out_size(bus_if.out_size), .in_req(bus_if.in_req), .out_req(bus_if.out_req),
		.in_level(bus_if.in_level), .out_level(bus_if.out_level), .busy(bus_if.busy), .done(bus_if.done));

	always #5 pclk = ~pclk;

	// Word source and stalling sink
	always @(posedge pclk) begin
		if (src_valid && src_ready) src_q.delete(0);
		src_valid <= (src_q.size() > 0);
		src_data <= (src_q.size() > 0) ? src_q[0] : ~src_data;
		if (dst_valid && dst_ready) for (int b = 0; b < (1 << dsz); b++) got_q.push_back(dst_data[8*b +: 8]);
		stall_cnt <= stall_cnt + 2'h1;
		dst_ready <= (stall_cnt != 2'h3);
	end

	task stop_test;
		if (n_mismatch == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : stop_test

	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd_data = prdata;
		rd_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Reference expansion with crop window
	function automatic void expand(input int f, w, sx, sy, ex, ey, input rld_bq_t c);
		int i, n, x, y, k, j;
		logic [7:0] cmd;
		exp_q = {};
		i = 0;
		x = 1;
		y = 1;
		while (i < c.size()) begin
			cmd = c[i];
			i++;
			n = int'(cmd[6:0]) + 1;
			for (k = 0; k < n; k++) begin
				if (x >= sx && x <= ex && y >= sy && y <= ey)
					for (j = 0; j <= f; j++) exp_q.push_back(c[i + j + (cmd[7] ? 0 : k * (f + 1))]);
				x++;
				if (x > w) begin
					x = 1;
					y++;
				end
			end
			i += cmd[7] ? f + 1 : n * (f + 1);
		end
	endfunction : expand

	task automatic run(input int f, w, h, sx, sy, ex, ey, fsz, input rld_bq_t c);
		int k;
		apb(`RLD_OFF_CTRL, 1'b1, 32'h1);
		apb(`RLD_OFF_CSIZE, 1'b1, 32'(c.size()));
		apb(`RLD_OFF_DIM, 1'b1, {16'(h), 16'(w)});
		apb(`RLD_OFF_START, 1'b1, {16'(sy), 16'(sx)});
		apb(`RLD_OFF_END, 1'b1, {16'(ey), 16'(ex)});
		apb(`RLD_OFF_ICFG, 1'b1, 32'(f));
		apb(`RLD_OFF_DMA_CTRL, 1'b1, 32'h3 | 32'(fsz << 2) | 32'(fsz << 4));
		expand(f, w, sx, sy, ex, ey, c);
		dsz = 2'(fsz);
		got_q = {};
		if (fsz == 2) for (k = 0; k < c.size(); k += 4) src_q.push_back({c[k+3], c[k+2], c[k+1], c[k]});
		else if (fsz == 1) for (k = 0; k < c.size(); k += 2) src_q.push_back({16'h0, c[k+1], c[k]});
		else for (k = 0; k < c.size(); k++) src_q.push_back({24'h0, c[k]});
		apb(`RLD_OFF_CTRL, 1'b1, 32'h0);
		for (k = 0; k < 5000 && got_q.size() < exp_q.size(); k++) @(posedge pclk);
		rd_data = 32'h0;
		for (k = 0; k < 50 && rd_data[0] !== 1'b1; k++) apb(`RLD_OFF_STAT, 1'b0, 32'h0);
		chk(32'(rd_data[1:0]), 32'h1, "done/busy");
		chk(32'(got_q.size()), 32'(exp_q.size()), "byte count");
		for (k = 0; k < exp_q.size(); k++) chk(got_q[k], exp_q[k], "pixel byte");
		n_words += exp_q.size() >> fsz;
	endtask : run

	task t_regs;
		apb(`RLD_OFF_STAT, 1'b0, 32'h0);
		chk(rd_data, 32'h0, "status after reset");
		apb(8'h3C, 1'b0, 32'h0);
		chk({31'h0, rd_err}, 32'h1, "unmapped error");
	endtask : t_regs

	task t_basic;
		rld_bq_t c;
		c = {8'h94, 8'hA5, 8'h02, 8'h11, 8'h22, 8'h33, 8'h87, 8'h5C};
		run(0, 16, 2, 1, 1, 16, 2, 2, c);
	endtask : t_basic

	task t_formats;
		rld_bq_t c;
		for (int f = 1; f < 4; f++) begin
			c = {8'h8B};
			for (int j = 0; j <= f; j++) c.push_back(8'(16 * f + j));
			c.push_back(8'h03);
			for (int j = 0; j < 4 * (f + 1); j++) c.push_back(8'(64 + j));
			run(f, 16, 1, 1, 1, 16, 1, 0, c);
		end
	endtask : t_formats

	task t_crop;
		rld_bq_t c;
		c = {8'h2F};
		for (int j = 0; j < 48; j++) c.push_back(8'(j));
		run(0, 8, 6, 3, 2, 6, 5, 0, c);
	endtask : t_crop

	task t_long;
		rld_bq_t c;
		c = {8'hFF, 8'h3C};
		run(0, 128, 1, 1, 1, 128, 1, 1, c);
		apb(`RLD_OFF_XFER, 1'b0, 32'h0);
		chk(rd_data, 32'(n_words), "delivered words");
	endtask : t_long

	initial begin
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		n_words = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_basic();
		t_formats();
		t_crop();
		t_long();
		stop_test();
	end

	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		stop_test();
	end
endmodule : run_length_stream_decoder_tb
